// ===== shared/ibps_pkg.sv
package ibps_pkg;

	// status byte layout
	localparam int STS_W          = 8;
	localparam int BIT_TROUBLE    = 0;
	localparam int BIT_POWER_UP   = 1;
	localparam int BIT_READY      = 4;
	localparam int BIT_BAD_CMD    = 5;
	localparam int BIT_RQS        = 6;

	// reset values of the flags
	localparam logic POWER_UP_RESET = 1'b1;
	localparam logic READY_RESET    = 1'b1;
	localparam logic RQS_RESET      = 1'b0;
	localparam logic BAD_CMD_RESET  = 1'b0;

	// address switches
	localparam int         ADDR_W          = 5;
	localparam logic [4:0] ADDR_RESET      = 5'h00;
	localparam logic [4:0] ADDR_INVALID    = 5'h1f;
	localparam logic [4:0] PP_DIRECT_LIMIT = 5'h08;

	// parallel poll configuration value
	localparam int        PP_CFG_W     = 4;
	localparam int        PP_SENSE_BIT = 3;
	localparam logic [3:0] PP_CFG_RESET = 4'h0;

	// data lines
	localparam logic [7:0] DATA_ALL  = 8'hff;
	localparam logic [7:0] DATA_NONE = 8'h00;
	localparam logic [7:0] LINE_ONE  = 8'h01;

	// start-up: pin synchronisers settle before the power-up request
	localparam logic [1:0] STARTUP_RESET = 2'h0;
	localparam logic [1:0] STARTUP_FIRE  = 2'h2;
	localparam logic [1:0] STARTUP_DONE  = 2'h3;

	// timing of the return-to-local key address display
	localparam int CLK_HZ         = 50000000;
	localparam int HOLD_TIME_S    = 1;
	localparam int DISPLAY_TIME_S = 2;
	localparam int HOLD_CYCLES    = HOLD_TIME_S * CLK_HZ;
	localparam int DISPLAY_CYCLES = DISPLAY_TIME_S * CLK_HZ;
	localparam int CNT_W          = 27;
	localparam logic [26:0] CNT_RESET = 27'h000_0000;

endpackage : ibps_pkg

// ===== src/ibps_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module ibps_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK_SYS,
	input  wire logic             SYS_RST,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	output var  logic [WIDTH-1:0] SYNC_OUT
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			meta_reg <= '0;
			SYNC_OUT <= '0;
		end else begin
			meta_reg <= ASYNC_IN;
			SYNC_OUT <= meta_reg;
		end
	end

endmodule : ibps_sync2

`default_nettype wire

// ===== src/ibps_top.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - serial poll, parallel poll, clear, trigger, remote/local
// - serial poll drives status byte, bit0 on line1
// - request flag set on request, cleared by poll
// - request line held until serial poll completes
// - bit 5 mirrors bad-command flag, query clears
// - bit 4 ready: set done, cleared start
// - command intake stays open while busy
// - bit 1 set at power-up, clear clears
// - bit 0 set by fault register, query clears
// - per-fault enable gates both fault latching and service requests
// - failed self test silences all bus answers
// - parallel poll answer follows request flag
// - default parallel poll: line address+1, below 8
// - configured parallel poll: sense and line chosen
// - parallel poll leaves request flag unchanged
// - lockout disables only return-to-local key
// - device clear acts addressed or unaddressed
// - trigger acts only when addressed to listen
// - address from five switches, 0 to 30
// - address 31 reported as self-test error
// - key held 1 s shows address, 2 s max
module ibps_top
	import ibps_pkg::*;
#(
	parameter int FAULT_N       = 8,
	parameter int HOLD_CYC      = HOLD_CYCLES,
	parameter int DISPLAY_CYC   = DISPLAY_CYCLES
) (
	input  wire logic               CLK_SYS,
	input  wire logic               SYS_RST,
	input  wire logic [ADDR_W-1:0]  ADDRESS_SWITCH,
	input  wire logic               POWER_UP_REQUEST_SWITCH,
	input  wire logic               RETURN_TO_LOCAL_KEY,
	input  wire logic [FAULT_N-1:0] FAULT_CONDITION,
	input  wire logic [FAULT_N-1:0] FAULT_ENABLE,
	input  wire logic               SELF_TEST_FAIL,
	input  wire logic               LISTEN_ADDRESSED,
	input  wire logic               TALK_ADDRESSED,
	input  wire logic               REMOTE_ENABLE,
	input  wire logic               GO_TO_LOCAL_MSG,
	input  wire logic               LOCAL_LOCKOUT_MSG,
	input  wire logic               SERIAL_POLL_ACTIVE,
	input  wire logic               SERIAL_POLL_DONE,
	input  wire logic               PARALLEL_POLL_ACTIVE,
	input  wire logic               PP_CONFIG_STROBE,
	input  wire logic [PP_CFG_W-1:0] PP_CONFIG_VALUE,
	input  wire logic               PP_UNCONFIGURE_MSG,
	input  wire logic               UNIVERSAL_CLEAR_MSG,
	input  wire logic               SELECTED_CLEAR_MSG,
	input  wire logic               TRIGGER_MSG,
	input  wire logic               CLEAR_COMMAND,
	input  wire logic               PROGRAM_ERROR,
	input  wire logic               ERROR_QUERY,
	input  wire logic               FAULT_QUERY,
	input  wire logic               CMD_START,
	input  wire logic               CMD_DONE,
	output var  logic [STS_W-1:0]   DATA_OUT,
	output var  logic [STS_W-1:0]   DATA_OE,
	output var  logic               SRQ_OE,
	output var  logic               SRQ_INDICATOR,
	output var  logic               LISTEN_INDICATOR,
	output var  logic               TALK_INDICATOR,
	output var  logic               REMOTE_INDICATOR,
	output var  logic               CLEAR_ACTION,
	output var  logic               TRIGGER_ACTION,
	output var  logic               CMD_ACCEPT,
	output var  logic [ADDR_W-1:0]  BUS_ADDRESS,
	output var  logic               ADDRESS_DISPLAY,
	output var  logic               SELF_TEST_ERROR,
	output var  logic [FAULT_N-1:0] FAULT_REGISTER
);

	// synchronised pins
	logic [ADDR_W-1:0]  addr_sw_s;
	logic [1:0]         keys_s;
	logic [FAULT_N-1:0] fault_cond_s;
	logic               pon_sw_s;
	logic               key_s;

	ibps_sync2 #(.WIDTH(ADDR_W)) u_sync_addr (
		.CLK_SYS  (CLK_SYS),
		.SYS_RST  (SYS_RST),
		.ASYNC_IN (ADDRESS_SWITCH),
		.SYNC_OUT (addr_sw_s)
	);

	ibps_sync2 #(.WIDTH(2)) u_sync_keys (
		.CLK_SYS  (CLK_SYS),
		.SYS_RST  (SYS_RST),
		.ASYNC_IN ({POWER_UP_REQUEST_SWITCH, RETURN_TO_LOCAL_KEY}),
		.SYNC_OUT (keys_s)
	);

	ibps_sync2 #(.WIDTH(FAULT_N)) u_sync_fault (
		.CLK_SYS  (CLK_SYS),
		.SYS_RST  (SYS_RST),
		.ASYNC_IN (FAULT_CONDITION),
		.SYNC_OUT (fault_cond_s)
	);

	assign pon_sw_s = keys_s[1];
	assign key_s    = keys_s[0];

	// state
	logic [1:0]          startup_reg,  startup_next;
	logic [ADDR_W-1:0]   addr_reg,     addr_next;
	logic                addr_err_reg, addr_err_next;
	logic [FAULT_N-1:0]  fault_reg,    fault_next;
	logic                rqs_reg,      rqs_next;
	logic                bad_cmd_reg,  bad_cmd_next;
	logic                ready_reg,    ready_next;
	logic                pon_reg,      pon_next;
	logic                pp_en_reg,    pp_en_next;
	logic [PP_CFG_W-1:0] pp_cfg_reg,   pp_cfg_next;
	logic                lockout_reg,  lockout_next;
	logic                remote_reg,   remote_next;
	logic [CNT_W-1:0]    hold_cnt_reg, hold_cnt_next;
	logic [CNT_W-1:0]    disp_cnt_reg, disp_cnt_next;
	logic                disp_reg,     disp_next;
	logic                disp_done_reg, disp_done_next;

	// decode
	logic               startup_fire;
	logic               startup_done;
	logic               silent;
	logic               fault_new;
	logic               srq_set;
	logic               poll_done;
	logic               clear_hit;
	logic [STS_W-1:0]   status_byte;
	logic               pp_bit;
	logic [2:0]         pp_line;
	logic [STS_W-1:0]   pp_lines;
	logic               sp_drive;
	logic               pp_drive;
	logic [STS_W-1:0]   data_out_next;
	logic [STS_W-1:0]   data_oe_next;
	logic               trig_hit;
	logic               key_free;
	logic               hold_end;
	logic               disp_end;

	assign startup_fire = (startup_reg == STARTUP_FIRE);
	assign startup_done = (startup_reg == STARTUP_DONE);
	assign startup_next = startup_done ? startup_reg
		: startup_reg + 2'h1;

	// keep last valid address; 31 is an error
	assign addr_next = (addr_sw_s != ADDR_INVALID) ? addr_sw_s
		: addr_reg;
	assign addr_err_next = startup_done
		&& (addr_sw_s == ADDR_INVALID);
	assign silent = SELF_TEST_FAIL | addr_err_reg;

	// enabled faults latch and raise a request
	assign fault_new = |(fault_cond_s & FAULT_ENABLE & ~fault_reg);
	assign fault_next = (fault_reg & ~{FAULT_N{FAULT_QUERY}})
		| (fault_cond_s & FAULT_ENABLE);
	assign srq_set = fault_new | (startup_fire & pon_sw_s);
	assign poll_done = SERIAL_POLL_DONE & ~silent;
	assign rqs_next = srq_set | (rqs_reg & ~poll_done);

	assign bad_cmd_next = PROGRAM_ERROR
		| (bad_cmd_reg & ~ERROR_QUERY);
	assign ready_next = CMD_DONE | (ready_reg & ~CMD_START);
	assign clear_hit = ~silent & (CLEAR_COMMAND | UNIVERSAL_CLEAR_MSG
		| (SELECTED_CLEAR_MSG & LISTEN_ADDRESSED));
	assign pon_next = pon_reg & ~clear_hit;

	always_comb begin
		status_byte = DATA_NONE;
		status_byte[BIT_RQS]      = rqs_reg;
		status_byte[BIT_BAD_CMD]  = bad_cmd_reg;
		status_byte[BIT_READY]    = ready_reg;
		status_byte[BIT_POWER_UP] = pon_reg;
		status_byte[BIT_TROUBLE]  = |fault_reg;
	end

	// parallel poll configuration
	assign pp_en_next = ~silent & PP_CONFIG_STROBE & LISTEN_ADDRESSED
		| pp_en_reg & ~(PP_UNCONFIGURE_MSG & ~silent);
	assign pp_cfg_next = (~silent & PP_CONFIG_STROBE & LISTEN_ADDRESSED)
		? PP_CONFIG_VALUE : pp_cfg_reg;

	// configured: drive when request flag equals sense
	assign pp_bit = pp_en_reg
		? (rqs_reg ~^ pp_cfg_reg[PP_SENSE_BIT])
		: (rqs_reg && addr_reg < PP_DIRECT_LIMIT);
	assign pp_line = pp_en_reg ? pp_cfg_reg[2:0] : addr_reg[2:0];
	assign pp_lines = (LINE_ONE << pp_line) & {STS_W{pp_bit}};

	assign sp_drive = SERIAL_POLL_ACTIVE & TALK_ADDRESSED & ~silent;
	assign pp_drive = PARALLEL_POLL_ACTIVE & ~silent & ~sp_drive;
	assign data_oe_next = sp_drive ? DATA_ALL
		: pp_drive ? pp_lines : DATA_NONE;
	assign data_out_next = sp_drive ? status_byte
		: pp_drive ? pp_lines : DATA_NONE;

	assign trig_hit = TRIGGER_MSG & LISTEN_ADDRESSED & ~silent;

	// remote/local; lockout masks only the key
	assign key_free = key_s & ~lockout_reg;
	assign lockout_next = REMOTE_ENABLE
		& (lockout_reg | (LOCAL_LOCKOUT_MSG & ~silent));
	assign remote_next = REMOTE_ENABLE & ~(GO_TO_LOCAL_MSG & ~silent)
		& ~key_free & (remote_reg | (LISTEN_ADDRESSED & ~silent));

	// address display on held key
	assign hold_end = (hold_cnt_reg == CNT_W'(HOLD_CYC - 1));
	assign disp_end = (disp_cnt_reg == CNT_W'(DISPLAY_CYC - 1));
	assign disp_next = key_s & ((disp_reg & ~disp_end)
		| (~disp_reg & ~disp_done_reg & hold_end));
	assign disp_done_next = key_s & (disp_done_reg
		| (disp_reg & disp_end));
	assign hold_cnt_next = (!key_s || hold_end) ? CNT_RESET
		: hold_cnt_reg + 1'b1;
	assign disp_cnt_next = !disp_reg ? CNT_RESET
		: disp_cnt_reg + 1'b1;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			startup_reg  <= STARTUP_RESET;
			addr_reg     <= ADDR_RESET;
			addr_err_reg <= 1'b0;
			fault_reg    <= '0;
			rqs_reg      <= RQS_RESET;
			bad_cmd_reg  <= BAD_CMD_RESET;
			ready_reg    <= READY_RESET;
			pon_reg      <= POWER_UP_RESET;
			pp_en_reg    <= 1'b0;
			pp_cfg_reg   <= PP_CFG_RESET;
			lockout_reg  <= 1'b0;
			remote_reg   <= 1'b0;
		end else begin
			startup_reg  <= startup_next;
			addr_reg     <= addr_next;
			addr_err_reg <= addr_err_next;
			fault_reg    <= fault_next;
			rqs_reg      <= rqs_next;
			bad_cmd_reg  <= bad_cmd_next;
			ready_reg    <= ready_next;
			pon_reg      <= pon_next;
			pp_en_reg    <= pp_en_next;
			pp_cfg_reg   <= pp_cfg_next;
			lockout_reg  <= lockout_next;
			remote_reg   <= remote_next;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			hold_cnt_reg  <= CNT_RESET;
			disp_cnt_reg  <= CNT_RESET;
			disp_reg      <= 1'b0;
			disp_done_reg <= 1'b0;
		end else begin
			hold_cnt_reg  <= hold_cnt_next;
			disp_cnt_reg  <= disp_cnt_next;
			disp_reg      <= disp_next;
			disp_done_reg <= disp_done_next;
		end
	end

	// registered outputs
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			DATA_OUT         <= DATA_NONE;
			DATA_OE          <= DATA_NONE;
			SRQ_OE           <= 1'b0;
			SRQ_INDICATOR    <= 1'b0;
			LISTEN_INDICATOR <= 1'b0;
			TALK_INDICATOR   <= 1'b0;
			REMOTE_INDICATOR <= 1'b0;
			CLEAR_ACTION     <= 1'b0;
			TRIGGER_ACTION   <= 1'b0;
			CMD_ACCEPT       <= 1'b0;
			BUS_ADDRESS      <= ADDR_RESET;
			ADDRESS_DISPLAY  <= 1'b0;
			SELF_TEST_ERROR  <= 1'b0;
			FAULT_REGISTER   <= '0;
		end else begin
			DATA_OUT         <= data_out_next;
			DATA_OE          <= data_oe_next;
			SRQ_OE           <= rqs_next & ~silent;
			SRQ_INDICATOR    <= rqs_next & ~silent;
			LISTEN_INDICATOR <= LISTEN_ADDRESSED & ~silent;
			TALK_INDICATOR   <= TALK_ADDRESSED & ~silent;
			REMOTE_INDICATOR <= remote_next;
			CLEAR_ACTION     <= clear_hit;
			TRIGGER_ACTION   <= trig_hit;
			CMD_ACCEPT       <= ~silent;
			BUS_ADDRESS      <= addr_next;
			ADDRESS_DISPLAY  <= disp_next;
			SELF_TEST_ERROR  <= addr_err_next;
			FAULT_REGISTER   <= fault_next;
		end
	end

	// checks
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);

	a_poll_clears_srq: assert property (
		poll_done && !srq_set |=> !SRQ_OE && !SRQ_INDICATOR && !rqs_reg)
		else $error("request not cleared by serial poll");

	a_srq_holds: assert property (
		SRQ_OE && !SERIAL_POLL_DONE && !silent |=> SRQ_OE)
		else $error("request line dropped without poll");

	a_poll_byte: assert property (
		sp_drive |=> DATA_OE == DATA_ALL
			&& DATA_OUT == $past(status_byte))
		else $error("serial poll byte wrong");

	a_unused_zero: assert property (
		sp_drive |=> !DATA_OUT[7] && DATA_OUT[3:2] == 2'h0)
		else $error("unused status bit not zero");

	a_silent_bus: assert property (
		SELF_TEST_FAIL |=> DATA_OE == DATA_NONE && !SRQ_OE)
		else $error("failed device answered the bus");

	a_pp_keeps_rqs: assert property (
		PARALLEL_POLL_ACTIVE && !poll_done && !srq_set
			|=> rqs_reg == $past(rqs_reg))
		else $error("parallel poll changed request flag");

	a_pp_high_addr: assert property (
		pp_drive && !pp_en_reg && addr_reg >= PP_DIRECT_LIMIT
			|=> DATA_OE == DATA_NONE)
		else $error("answer at address 8 or above");

	a_trig_unaddr: assert property (
		TRIGGER_MSG && !LISTEN_ADDRESSED |=> !TRIGGER_ACTION)
		else $error("trigger while not addressed");

	a_clear_pon: assert property (
		UNIVERSAL_CLEAR_MSG && !silent |=> CLEAR_ACTION && !pon_reg)
		else $error("device clear not acted on");

	a_bad_cmd_hold: assert property (
		bad_cmd_reg && !ERROR_QUERY |=> bad_cmd_reg)
		else $error("bad-command flag lost");

	a_disp_release: assert property (
		ADDRESS_DISPLAY && !key_s |=> !ADDRESS_DISPLAY)
		else $error("display outlived key release");

	a_addr_invalid: assert property (
		startup_done && addr_sw_s == ADDR_INVALID
			|=> SELF_TEST_ERROR && $stable(BUS_ADDRESS))
		else $error("address 31 not reported");

	c_serial_poll: cover property (sp_drive && rqs_reg ##1 poll_done);
	c_pp_config: cover property (pp_drive && pp_en_reg && pp_bit);
	c_display: cover property ($rose(ADDRESS_DISPLAY));
	c_trigger: cover property (TRIGGER_ACTION);

endmodule : ibps_top

`default_nettype wire

// ===== verification/ibps_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module ibps_ctrl_model
	import ibps_pkg::*;
(
	input wire logic             clk,
	input wire logic [STS_W-1:0] data_out,
	input wire logic [STS_W-1:0] data_oe
);
	localparam int WAIT_MAX = 8;
	logic                talk;
	logic                listen;
	logic                ren;
	logic                spa;
	logic                ppa;
	logic                look;
	logic [7:0]          msg;
	logic [PP_CFG_W-1:0] ppv;
	logic [STS_W-1:0]    seen;

	initial begin
		{talk, listen, ren, spa, ppa, look, msg, ppv, seen} = '0;
	end

	// level seen on the open-drain data lines
	task automatic grab();
		seen = data_oe & data_out;
		look = 1'b1;
	endtask : grab

	// one-cycle message, addressed to listen or not
	task automatic send(input int k, input logic addr);
		@(posedge clk);
		#1 listen = addr;
		msg[k] = 1'b1;
		@(posedge clk);
		#1 msg[k] = 1'b0;
		listen = 1'b0;
		ppv = ~ppv;
	endtask : send

	// gives up on a silent device after WAIT_MAX cycles
	task automatic serial_poll(output logic ok);
		int n;
		n = 0;
		@(posedge clk);
		#1 talk = 1'b1;
		spa = 1'b1;
		do begin
			@(posedge clk);
			#1 n = n + 1;
		end while (data_oe !== DATA_ALL && n < WAIT_MAX);
		ok = (data_oe === DATA_ALL);
		if (ok) grab();
		msg[0] = ok;
		@(posedge clk);
		#1 {msg[0], look, spa, talk} = '0;
	endtask : serial_poll

	task automatic parallel_poll();
		@(posedge clk);
		#1 ppa = 1'b1;
		@(posedge clk);
		#1 grab();
		ppa = 1'b0;
		@(posedge clk);
		#1 look = 1'b0;
	endtask : parallel_poll

endmodule : ibps_ctrl_model

`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench
	import ibps_pkg::*;
;
	localparam int HOLD = 10;
	localparam int SHOW = 20;
	localparam int L_CLR = 0, L_ERR = 1, L_EQ = 2, L_FQ = 3, L_CS = 4, L_CD = 5;
	typedef struct {string nm; logic [7:0] v; logic [7:0] m;} ibps_note_s;
	ibps_note_s q[$];
	ibps_note_s nt;
	int         errors;
	int         n_tests;
	int         k;
	int         cnt;
	logic       clk, rst, pu_sw, key, st_fail, ok;
	logic [4:0] addr_sw, bus_addr;
	logic [7:0] f_cond, f_en, f_reg, d_out, d_oe;
	logic [5:0] lp;
	logic       srq, srq_ind, remote, clr_act, trg_act, accept, disp, st_err;
	logic       lsn_ind, tlk_ind;

	ibps_ctrl_model ctl (.clk(clk), .data_out(d_out), .data_oe(d_oe));

	ibps_top #(.HOLD_CYC(HOLD), .DISPLAY_CYC(SHOW)) i_dut (
		.CLK_SYS(clk), .SYS_RST(rst), .ADDRESS_SWITCH(addr_sw),
		.POWER_UP_REQUEST_SWITCH(pu_sw), .RETURN_TO_LOCAL_KEY(key),
		.FAULT_CONDITION(f_cond), .FAULT_ENABLE(f_en),
		.SELF_TEST_FAIL(st_fail), .LISTEN_ADDRESSED(ctl.listen),
		.TALK_ADDRESSED(ctl.talk), .REMOTE_ENABLE(ctl.ren),
		.GO_TO_LOCAL_MSG(ctl.msg[6]), .LOCAL_LOCKOUT_MSG(ctl.msg[7]),
		.SERIAL_POLL_ACTIVE(ctl.spa), .SERIAL_POLL_DONE(ctl.msg[0]),
		.PARALLEL_POLL_ACTIVE(ctl.ppa), .PP_CONFIG_STROBE(ctl.msg[1]),
		.PP_CONFIG_VALUE(ctl.ppv), .PP_UNCONFIGURE_MSG(ctl.msg[2]),
		.UNIVERSAL_CLEAR_MSG(ctl.msg[3]), .SELECTED_CLEAR_MSG(ctl.msg[4]),
		.TRIGGER_MSG(ctl.msg[5]), .CLEAR_COMMAND(lp[0]),
		.PROGRAM_ERROR(lp[1]), .ERROR_QUERY(lp[2]), .FAULT_QUERY(lp[3]),
		.CMD_START(lp[4]), .CMD_DONE(lp[5]), .DATA_OUT(d_out),
		.DATA_OE(d_oe), .SRQ_OE(srq), .SRQ_INDICATOR(srq_ind),
		.LISTEN_INDICATOR(lsn_ind), .TALK_INDICATOR(tlk_ind),
		.REMOTE_INDICATOR(remote),
		.CLEAR_ACTION(clr_act), .TRIGGER_ACTION(trg_act),
		.CMD_ACCEPT(accept), .BUS_ADDRESS(bus_addr),
		.ADDRESS_DISPLAY(disp), .SELF_TEST_ERROR(st_err),
		.FAULT_REGISTER(f_reg));

	always #10 clk = ~clk;

	task automatic summarize();
		`CHK("notes left", 0, q.size())
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic lpulse(input int i);
		step(1);
		lp[i] = 1'b1;
		step(1);
		lp[i] = 1'b0;
	endtask : lpulse

	task automatic act(input logic c, input logic t);
		`CHK("clear action", c, clr_act)
		`CHK("trigger action", t, trg_act)
		step(1);
		`CHK("action end", 2'b00, {clr_act, trg_act})
	endtask : act

	task automatic spoll(input string nm, input logic [7:0] v,
		input logic [7:0] m);
		q.push_back('{nm, v, m});
		ctl.serial_poll(ok);
		`CHK("answered", 1'b1, ok)
		step(1);
	endtask : spoll

	task automatic ppoll(input string nm, input logic [7:0] v);
		q.push_back('{nm, v, 8'hff});
		ctl.parallel_poll();
	endtask : ppoll

	task automatic silent();
		ctl.serial_poll(ok);
		`CHK("no answer", 1'b0, ok)
	endtask : silent

	// oldest note against each poll answer
	always @(posedge clk) begin
		if (ctl.look === 1'b1) begin
			if (q.size() == 0) begin
				nt = '{"extra poll", 8'hxx, 8'hff};
			end else begin
				nt = q.pop_front();
			end
			`CHK(nt.nm, nt.v & nt.m, ctl.seen & nt.m)
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		{rst, pu_sw, key, st_fail, lp} = {4'b1100, 6'h00};
		{f_cond, f_en} = '0;
		addr_sw = 5'h05;
		errors = 0;
		n_tests = 0;
		void'($urandom(28029));
		k = $urandom % 8;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		step(6);
		`CHK("request line", 1'b1, srq)
		`CHK("request lamp", 1'b1, srq_ind)
		spoll("power-up byte", 8'h52, 8'hff);
		`CHK("line after poll", 1'b0, srq)
		spoll("after poll", 8'h12, 8'hff);
		$display("test power_up done");
		lpulse(L_ERR);
		spoll("error set", 8'h32, 8'hbf);
		lpulse(L_CS);
		`CHK("intake open", 1'b1, accept)
		spoll("busy", 8'h22, 8'hbf);
		lpulse(L_CD);
		lpulse(L_EQ);
		spoll("ready again", 8'h12, 8'hbf);
		lpulse(L_CLR);
		act(1'b1, 1'b0);
		spoll("power-up cleared", 8'h10, 8'hbf);
		$display("test flags done");
		f_cond[(k + 1) % 8] = 1'b1;
		step(6);
		`CHK("masked fault", 8'h00, f_reg)
		`CHK("no request", 1'b0, srq)
		f_en[k] = 1'b1;
		f_cond[k] = 1'b1;
		step(6);
		`CHK("fault latch", 8'h01 << k, f_reg)
		`CHK("fault request", 1'b1, srq)
		ppoll("default answer", 8'h20);
		`CHK("kept request", 1'b1, srq)
		addr_sw = 5'h09;
		step(6);
		`CHK("address", 5'h09, bus_addr)
		ppoll("high address", 8'h00);
		for (int i = 0; i < 32; i++) begin
			if (i == 16) spoll("fault byte", 8'h51, 8'hff);
			ctl.ppv = i[3:0];
			ctl.send(1, 1'b1);
			ppoll("configured",
				((i < 16) == i[3]) ? 8'h01 << i[2:0] : 8'h00);
		end
		f_cond = 8'h00;
		step(4);
		lpulse(L_FQ);
		step(1);
		`CHK("fault cleared", 8'h00, f_reg)
		spoll("fault byte cleared", 8'h10, 8'hff);
		ctl.ppv = 4'h2;
		ctl.send(1, 1'b1);
		ppoll("sense low", 8'h04);
		ctl.send(2, 1'b0);
		ppoll("unconfigured", 8'h00);
		$display("test faults and polls done");
		ctl.send(5, 1'b0);
		act(1'b0, 1'b0);
		ctl.send(5, 1'b1);
		act(1'b0, 1'b1);
		ctl.send(3, 1'b0);
		act(1'b1, 1'b0);
		ctl.send(4, 1'b1);
		act(1'b1, 1'b0);
		$display("test clear and trigger done");
		ctl.ren = 1'b1;
		ctl.listen = 1'b1;
		ctl.talk = 1'b1;
		step(2);
		`CHK("remote", 1'b1, remote)
		`CHK("lamps", 2'b11, {lsn_ind, tlk_ind})
		ctl.listen = 1'b0;
		ctl.talk = 1'b0;
		key = 1'b1;
		step(5);
		`CHK("key to local", 1'b0, remote)
		key = 1'b0;
		ctl.listen = 1'b1;
		step(5);
		ctl.listen = 1'b0;
		ctl.send(7, 1'b0);
		key = 1'b1;
		cnt = 0;
		repeat (2 * SHOW) begin
			step(1);
			cnt += disp;
		end
		`CHK("lockout holds", 1'b1, remote)
		`CHK("display span", SHOW, cnt)
		ctl.send(6, 1'b0);
		`CHK("go to local", 1'b0, remote)
		key = 1'b0;
		$display("test remote done");
		addr_sw = 5'h1f;
		step(6);
		`CHK("switch error", 1'b1, st_err)
		`CHK("address kept", 5'h09, bus_addr)
		silent();
		addr_sw = 5'h09;
		st_fail = 1'b1;
		step(6);
		`CHK("intake shut", 1'b0, accept)
		silent();
		ctl.send(5, 1'b1);
		`CHK("lamp masked", 1'b0, lsn_ind)
		act(1'b0, 1'b0);
		$display("test silent done");
		summarize();
	end

endmodule : testbench

`default_nettype wire
